// *** design/gpio_port_pkg.sv ***
// package for the eight-bit general-purpose port
// assumes an ahb-lite register slave on hclk, word-aligned registers
package gpio_port_pkg;

	localparam int unsigned pin_count = 8;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] pin_direction_addr = 8'h00;
	localparam logic [7:0] pin_level_port_addr = 8'h04;
	localparam logic [7:0] output_latch_addr = 8'h08;
	localparam logic [7:0] analog_select_addr = 8'h0c;
	localparam logic [7:0] slew_rate_control_addr = 8'h10;
	localparam logic [7:0] oscillator_claim_addr = 8'h14;

	// ==========================================================
	// values after reset
	localparam logic [7:0] pin_direction_reset = 8'hff;
	localparam logic [7:0] output_latch_reset = 8'h00;
	localparam logic [7:0] analog_select_reset = 8'h2f;
	localparam logic [7:0] slew_rate_control_reset = 8'hff;
	localparam logic oscillator_claim_reset = 1'b0;

	// ==========================================================
	// field positions
	localparam int unsigned osc_pin_low = 6;
	localparam int unsigned osc_pin_high = 7;
	localparam logic [7:0] osc_pin_mask = 8'hc0;

	// ahb-lite codes
	localparam logic [1:0] htrans_nonseq = 2'b10;
	localparam logic [2:0] hsize_word = 3'b010;

endpackage : gpio_port_pkg

// *** design/pin_level_sync.sv ***
// two-stage synchroniser for the pad input levels
// assumes pads may change at any time relative to hclk
module pin_level_sync
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// levels
	input wire logic [7:0] pad_level,
	output logic [7:0] synced_level
);

	logic [7:0] first_stage;

	// only the second stage reads the first
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			first_stage <= 8'h00;
			synced_level <= 8'h00;
		end
		else
		begin
			first_stage <= pad_level; // [R15]
			synced_level <= first_stage; // [R15]
		end
	end

endmodule : pin_level_sync

// *** design/eight_bit_gpio_port.sv ***
// eight-bit general-purpose port with direction, level, latch and analog registers
// assumes a single ahb-lite master, whole-word single transfers, pads synchronous-safe
// How it works
// R1: eight two-way pins, each with direction, latch, level and analog bit
// R2: direction bit one turns the pin driver off, pin is input
// R3: direction bit zero drives the pin from its latch bit
// R4: level register reads pins; writes land in the output latch
// R5: latch register reads back latched values, not pin levels
// R6: six registers: direction, level, latch, analog select, slew rate, oscillator claim
// R7: pins six and seven go to oscillator or port per configuration
// R8: oscillator-owned pins read zero in level, direction and latch
// R9: analog bits for pins five and zero to three set after reset
// R10: analog pins read zero in the level register
// R11: pin four comes up a digital input after reset
// R12: direction bits still steer drivers on analog pins; software keeps them set
// R13: enabled peripheral owns its pin over port use
// R14: both write paths update one latch bit per pin
// R15: pin levels pass a synchronising stage before reads
module eight_bit_gpio_port
(
	// ahb-lite slave
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// pads
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe,
	output logic [7:0] pad_slew_limited,
	// configuration and peripheral sharing
	input wire logic osc_config_claims,
	input wire logic [7:0] periph_enable,
	input wire logic [7:0] periph_out,
	input wire logic [7:0] periph_oe
);

	// ==========================================================
	// registers
	logic [7:0] pin_direction;
	logic [7:0] output_latch;
	logic [7:0] analog_select;
	logic [7:0] slew_rate_control;
	logic oscillator_claim;
	logic [7:0] synced_level;

	// ==========================================================
	// bus address phase capture
	logic wr_pending;
	logic [7:0] wr_addr;
	logic take_access;
	logic [7:0] next_rdata;
	logic [7:0] osc_keep;

	assign take_access = hsel && hready && htrans == gpio_port_pkg::htrans_nonseq;

	// combinational mask clearing the oscillator pins when claimed
	assign osc_keep = oscillator_claim ? ~gpio_port_pkg::osc_pin_mask : 8'hff; // [R8]

	pin_level_sync u_sync
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.pad_level(pad_in),
		.synced_level(synced_level)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pending <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pending <= take_access && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// strap sampled on every clock after release, never under reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			oscillator_claim <= gpio_port_pkg::oscillator_claim_reset;
		else
			oscillator_claim <= osc_config_claims; // [R7]
	end

	// ==========================================================
	// register writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pin_direction <= gpio_port_pkg::pin_direction_reset; // [R11]
		else if (wr_pending && wr_addr == gpio_port_pkg::pin_direction_addr)
			pin_direction <= hwdata[7:0];
	end

	// level and latch writes share one latch: [R4] [R14]
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			output_latch <= gpio_port_pkg::output_latch_reset;
		else if (wr_pending && (wr_addr == gpio_port_pkg::pin_level_port_addr
			|| wr_addr == gpio_port_pkg::output_latch_addr))
			output_latch <= hwdata[7:0]; // [R14]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			analog_select <= gpio_port_pkg::analog_select_reset; // [R9] [R11]
		else if (wr_pending && wr_addr == gpio_port_pkg::analog_select_addr)
			analog_select <= hwdata[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			slew_rate_control <= gpio_port_pkg::slew_rate_control_reset;
		else if (wr_pending && wr_addr == gpio_port_pkg::slew_rate_control_addr)
			slew_rate_control <= hwdata[7:0]; // [R6]
	end

	// ==========================================================
	// read mux, registered in the address phase
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (haddr[7:0])
			gpio_port_pkg::pin_direction_addr:
				next_rdata = pin_direction & osc_keep; // [R8]
			gpio_port_pkg::pin_level_port_addr:
				next_rdata = synced_level & ~analog_select & osc_keep; // [R4] [R10] [R8]
			gpio_port_pkg::output_latch_addr:
				next_rdata = output_latch & osc_keep; // [R5] [R8]
			gpio_port_pkg::analog_select_addr:
				next_rdata = analog_select;
			gpio_port_pkg::slew_rate_control_addr:
				next_rdata = slew_rate_control;
			gpio_port_pkg::oscillator_claim_addr:
				next_rdata = {7'h00, oscillator_claim};
			default:
				next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (take_access && !hwrite)
			hrdata <= {24'h00_0000, next_rdata};
	end

	// zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// pad drivers; oscillator claim beats peripheral, peripheral beats port
	logic [7:0] next_pad_out;
	logic [7:0] next_pad_oe;

	// one pad bit: oscillator pins never driven, an enabled peripheral owns its pin
	function automatic logic pick_drive(input logic keep, input logic periph_on,
		input logic periph_val, input logic port_val);
		if (!keep)
			return 1'b0; // [R7]
		else if (periph_on)
			return periph_val; // [R13]
		else
			return port_val;
	endfunction : pick_drive

	// one process owns each pad vector, so bits never have split drivers
	genvar i;
	generate
		for (i = 0; i < gpio_port_pkg::pin_count; i++)
		begin : g_pin
			// analog pins still obey direction [R12]
			assign next_pad_out[i] = pick_drive(osc_keep[i], periph_enable[i], periph_out[i],
				output_latch[i]); // [R3]
			assign next_pad_oe[i] = pick_drive(osc_keep[i], periph_enable[i], periph_oe[i],
				~pin_direction[i]); // [R2] [R3] [R1]
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pad_out <= 8'h00;
			pad_oe <= 8'h00;
			pad_slew_limited <= gpio_port_pkg::slew_rate_control_reset;
		end
		else
		begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
			pad_slew_limited <= slew_rate_control; // [R6]
		end
	end

	// ==========================================================
	// checks
	property p_direction_drives;
		@(posedge hclk) disable iff (!hresetn)
		(!periph_enable[0] && !pin_direction[0])
		|=> (pad_oe[0] && pad_out[0] == $past(output_latch[0]));
	endproperty
	a_direction_drives: assert property (p_direction_drives) // [R3]
		else $error("pin 0 not driven from latch");

	property p_direction_input;
		@(posedge hclk) disable iff (!hresetn)
		(!periph_enable[1] && pin_direction[1]) |=> !pad_oe[1];
	endproperty
	a_direction_input: assert property (p_direction_input) // [R2]
		else $error("input pin still driven");

	property p_level_write_latch;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pending && wr_addr == gpio_port_pkg::pin_level_port_addr)
		|=> output_latch == $past(hwdata[7:0]);
	endproperty
	a_level_write_latch: assert property (p_level_write_latch) // [R4]
		else $error("level write missed latch");

	property p_latch_readback;
		@(posedge hclk) disable iff (!hresetn)
		(take_access && !hwrite && haddr[7:0] == gpio_port_pkg::output_latch_addr)
		|=> hrdata[7:0] == ($past(output_latch) & $past(osc_keep));
	endproperty
	a_latch_readback: assert property (p_latch_readback) else $error("latch read wrong"); // [R5]

	property p_analog_reads_zero;
		@(posedge hclk) disable iff (!hresetn)
		(take_access && !hwrite && haddr[7:0] == gpio_port_pkg::pin_level_port_addr)
		|=> (hrdata[7:0] & $past(analog_select)) == 8'h00;
	endproperty
	a_analog_reads_zero: assert property (p_analog_reads_zero) // [R10]
		else $error("analog pin read nonzero");

	property p_osc_pins_idle;
		@(posedge hclk) disable iff (!hresetn)
		oscillator_claim |=> pad_oe[7:6] == 2'b00;
	endproperty
	a_osc_pins_idle: assert property (p_osc_pins_idle) // [R7]
		else $error("oscillator pin driven");

	property p_osc_dir_zero;
		@(posedge hclk) disable iff (!hresetn)
		(oscillator_claim && take_access && !hwrite && haddr[7:0] == gpio_port_pkg::pin_direction_addr)
		|=> hrdata[7:6] == 2'b00;
	endproperty
	a_osc_dir_zero: assert property (p_osc_dir_zero) // [R8]
		else $error("oscillator direction read nonzero");

	property p_periph_wins;
		@(posedge hclk) disable iff (!hresetn)
		(periph_enable[2] && !oscillator_claim) |=> pad_oe[2] == $past(periph_oe[2]);
	endproperty
	a_periph_wins: assert property (p_periph_wins) else $error("peripheral lost pin"); // [R13]

	property p_sync_two_cycles;
		@(posedge hclk) disable iff (!hresetn)
		$changed(pad_in) ##1 $stable(pad_in) |=> synced_level == $past(pad_in, 2);
	endproperty
	a_sync_two_cycles: assert property (p_sync_two_cycles) // [R15]
		else $error("sync delay wrong");

	property p_upper_read_zero;
		@(posedge hclk) disable iff (!hresetn)
		(take_access && !hwrite) |=> hrdata[31:8] == 24'h00_0000;
	endproperty
	a_upper_read_zero: assert property (p_upper_read_zero) // [R1]
		else $error("read data above the low byte nonzero");

	property p_direction_write;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pending && wr_addr == gpio_port_pkg::pin_direction_addr)
		|=> pin_direction == $past(hwdata[7:0]);
	endproperty
	a_direction_write: assert property (p_direction_write) // [R2]
		else $error("direction write lost");

	property p_latch_write;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pending && wr_addr == gpio_port_pkg::output_latch_addr)
		|=> output_latch == $past(hwdata[7:0]);
	endproperty
	a_latch_write: assert property (p_latch_write) // [R14]
		else $error("latch write lost");

	property p_slew_follows;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> pad_slew_limited == $past(slew_rate_control);
	endproperty
	a_slew_follows: assert property (p_slew_follows) // [R6]
		else $error("slew pads not following register");

	property p_osc_out_quiet;
		@(posedge hclk) disable iff (!hresetn)
		oscillator_claim
		|=> pad_out[gpio_port_pkg::osc_pin_high:gpio_port_pkg::osc_pin_low] == 2'b00;
	endproperty
	a_osc_out_quiet: assert property (p_osc_out_quiet) // [R7]
		else $error("oscillator pin output value nonzero");

	property p_osc_level_zero;
		@(posedge hclk) disable iff (!hresetn)
		(oscillator_claim && take_access && !hwrite
			&& haddr[7:0] == gpio_port_pkg::pin_level_port_addr)
		|=> hrdata[7:6] == 2'b00;
	endproperty
	a_osc_level_zero: assert property (p_osc_level_zero) // [R8]
		else $error("oscillator level read nonzero");

	property p_analog_dir_steers;
		@(posedge hclk) disable iff (!hresetn)
		(analog_select[1] && !periph_enable[1] && !pin_direction[1]) |=> pad_oe[1];
	endproperty
	a_analog_dir_steers: assert property (p_analog_dir_steers) // [R12]
		else $error("analog pin ignored its direction bit");

	property p_level_reads_pins;
		@(posedge hclk) disable iff (!hresetn)
		(!oscillator_claim && take_access && !hwrite
			&& haddr[7:0] == gpio_port_pkg::pin_level_port_addr)
		|=> hrdata[7:0] == ($past(synced_level) & ~$past(analog_select));
	endproperty
	a_level_reads_pins: assert property (p_level_reads_pins) // [R4]
		else $error("level read not the synced pins");

endmodule : eight_bit_gpio_port

// *** sim/pad_board_model.sv ***
// board side of the eight port pins
// assumes the bench sets what the board puts on pins the port leaves undriven
module pad_board_model
(
	// from the port
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	// board drive
	input wire logic [7:0] board_level,
	// to the port
	output logic [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// pin resolution
	// a driven pin shows the port value, an undriven one the board value
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_level);
endmodule : pad_board_model

// *** sim/eight_bit_gpio_port_tb.sv ***
// self-checking bench for the eight-bit port
// assumes the board model on the pads, one ahb-lite master here
module eight_bit_gpio_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, osc_config_claims;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] pad_in, pad_out, pad_oe, pad_slew_limited, board_level;
	logic [7:0] periph_enable, periph_out, periph_oe;
	int failures, n_checks;
	typedef struct packed {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} row_s;
	row_s rows [7] = '{
		'{gpio_port_pkg::pin_direction_addr, 8'h00, gpio_port_pkg::pin_direction_addr, 8'h00},
		'{gpio_port_pkg::pin_level_port_addr, 8'ha5, gpio_port_pkg::output_latch_addr, 8'ha5},
		'{gpio_port_pkg::output_latch_addr, 8'h3c, gpio_port_pkg::output_latch_addr, 8'h3c},
		'{gpio_port_pkg::analog_select_addr, 8'h00, gpio_port_pkg::analog_select_addr, 8'h00},
		'{gpio_port_pkg::slew_rate_control_addr, 8'h0f, gpio_port_pkg::slew_rate_control_addr, 8'h0f},
		'{gpio_port_pkg::oscillator_claim_addr, 8'hff, gpio_port_pkg::oscillator_claim_addr, 8'h00},
		'{8'h18, 8'hff, 8'h18, 8'h00}};

	eight_bit_gpio_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_slew_limited(pad_slew_limited),
		.osc_config_claims(osc_config_claims), .periph_enable(periph_enable),
		.periph_out(periph_out), .periph_oe(periph_oe));
	pad_board_model board (.pad_out(pad_out), .pad_oe(pad_oe), .board_level(board_level),
		.pad_in(pad_in));

	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// ==========================================================
	// checking and bus tasks
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic cmp(input string what, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, ex, got);
		end
	endtask : cmp
	task automatic cmp_pad(input string what, input logic [7:0] ex, input logic [7:0] got);
		cmp(what, {24'h0, ex}, {24'h0, got});
	endtask : cmp_pad
	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask : idle
	// no wait is assumed: the slave's ready decides, bounded
	task automatic wait_ready;
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			i++;
			if (i > 100)
			begin
				failures++;
				tally_and_finish();
			end
			@(posedge hclk);
		end
	endtask : wait_ready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= gpio_port_pkg::htrans_nonseq;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		wait_ready();
		rd = hrdata;
	endtask : xfer
	// idle after a write: one spare cycle; a read right behind it would already see the new register value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
		idle(1);
	endtask : wr
	task automatic chk(input string what, input logic [7:0] a, input logic [7:0] ex);
		xfer(1'b0, a, 8'h00);
		cmp(what, {24'h0, ex}, rd);
		cmp_pad("resp", 8'h00, {7'h00, hresp});
	endtask : chk

	// ==========================================================
	// main sequence
	initial
	begin
		failures = 0;
		n_checks = 0;
		{hresetn, hsel, hwrite, osc_config_claims} = 4'h0;
		{haddr, hwdata, htrans} = '0;
		hsize = gpio_port_pkg::hsize_word;
		board_level = 8'hff;
		{periph_enable, periph_out, periph_oe} = '0;
		idle(20);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("dir", gpio_port_pkg::pin_direction_addr, 8'hff);
		chk("latch", gpio_port_pkg::output_latch_addr, 8'h00);
		chk("analog", gpio_port_pkg::analog_select_addr, 8'h2f);
		chk("level", gpio_port_pkg::pin_level_port_addr, 8'hd0);
		cmp_pad("oe", 8'h00, pad_oe);
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd);
			chk("row", rows[i].ra, rows[i].ex);
		end
		cmp_pad("slew", 8'h0f, pad_slew_limited);
		idle(3);
		cmp_pad("out", 8'h3c, pad_out);
		cmp_pad("oe", 8'hff, pad_oe);
		chk("level", gpio_port_pkg::pin_level_port_addr, 8'h3c);
		wr(gpio_port_pkg::pin_direction_addr, 8'hff);
		board_level <= 8'hc3;
		idle(4);
		cmp_pad("oe", 8'h00, pad_oe);
		chk("level", gpio_port_pkg::pin_level_port_addr, 8'hc3);
		chk("latch", gpio_port_pkg::output_latch_addr, 8'h3c);
		osc_config_claims <= 1'b1;
		wr(gpio_port_pkg::output_latch_addr, 8'hff);
		idle(3);
		chk("dir", gpio_port_pkg::pin_direction_addr, 8'h3f);
		chk("latch", gpio_port_pkg::output_latch_addr, 8'h3f);
		chk("level", gpio_port_pkg::pin_level_port_addr, 8'h03);
		chk("claim", gpio_port_pkg::oscillator_claim_addr, 8'h01);
		wr(gpio_port_pkg::pin_direction_addr, 8'h00);
		idle(3);
		cmp_pad("oe", 8'h3f, pad_oe);
		periph_enable <= 8'h05;
		periph_oe <= 8'h05;
		idle(3);
		cmp_pad("out", 8'h3a, pad_out & 8'h3f);
		osc_config_claims <= 1'b0;
		wr(gpio_port_pkg::analog_select_addr, 8'hff);
		idle(3);
		cmp_pad("oe", 8'hff, pad_oe);
		chk("level", gpio_port_pkg::pin_level_port_addr, 8'h00);
		// mid-run reset; peripherals released so no pad is owned across it
		hresetn <= 1'b0;
		periph_enable <= 8'h00;
		periph_oe <= 8'h00;
		idle(2);
		cmp_pad("oe", 8'h00, pad_oe);
		cmp_pad("slew", 8'hff, pad_slew_limited);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("latch", gpio_port_pkg::output_latch_addr, 8'h00);
		chk("analog", gpio_port_pkg::analog_select_addr, 8'h2f);
		chk("level", gpio_port_pkg::pin_level_port_addr, 8'hc0);
		tally_and_finish();
	end
endmodule : eight_bit_gpio_port_tb
